// ==== core/lrc_defs.svh ====
`ifndef LRC_DEFS_SVH
`define LRC_DEFS_SVH
// Operation
// [R01] Undervoltage action: 00 ignore, 01 regulator off, 10 system reset, 11 reserved.
// [R02] Undervoltage always raises an interrupt, whatever the action field holds.
// [R03] Hardware-control source: 00 off, 01 input 1, 10 input 2, 11 either.
// [R04] Under hardware control, voltage select 0 uses ON code, 1 uses SLEEP code.
// [R05] Hardware-control mode: 00/10 low power, 01 off, 11 follow ON mode.
// [R06] Disabled regulator output discharges when float bit is 0, floats when 1.
// [R07] Low-power variant bit picks 50mA (0) or 20mA (1) wherever low power applies.
// [R08] Slot 000 never, 001-101 timeslots 1-5, 110/111 hardware enable 1/2.
// [R09] In ON state, mode bit 0 is normal, 1 is low power.
// [R10] Codes 00h-0Eh map to 0.9V-1.6V in 50mV steps.
// [R11] Codes 0Fh-1Fh map to 1.7V-3.3V in 100mV steps; 1Fh is maximum.
// [R12] Reset loads hardware-control mode 10; every other field loads zero (the code loads the SLEEP mode bit as 1).
// [R13] Separate 5-bit SLEEP voltage code, coded like the ON code.
// [R14] Selected hardware input asserted applies HWC settings; deasserted returns to ON.
// [R15] Slot-assigned regulator enables only when the sequencer reaches its slot.

// Register byte addresses (index times four).
`define LRC_IDX_CTRL 16'h4068
`define LRC_IDX_ON 16'h4069
`define LRC_IDX_SLP 16'h406a
`define LRC_ADDR_CTRL 18'h101a0
`define LRC_ADDR_ON 18'h101a4
`define LRC_ADDR_SLP 18'h101a8
`define LRC_ADDR_IRQ_STAT 18'h101b0
`define LRC_ADDR_IRQ_MASK 18'h101b4
`define LRC_ADDR_STATUS 18'h101b8
// Field positions in the control register.
`define LRC_ERR_HI 15
`define LRC_ERR_LO 14
`define LRC_SRC_HI 12
`define LRC_SRC_LO 11
`define LRC_HVSEL_BIT 10
`define LRC_HMODE_HI 9
`define LRC_HMODE_LO 8
`define LRC_FLT_BIT 7
`define LRC_SWI_BIT 6
`define LRC_LP_BIT 0
// Field positions in the ON and SLEEP registers.
`define LRC_SLOT_HI 15
`define LRC_SLOT_LO 13
`define LRC_MODE_BIT 8
`define LRC_VSEL_HI 4
`define LRC_VSEL_LO 0
// Reset values.
`define LRC_CTRL_RST 16'h0200
`define LRC_ON_RST 16'h0000
`define LRC_SLP_RST 16'h0100
// Voltage code mapping in millivolts.
`define LRC_MV_BASE_LO 16'd900
`define LRC_MV_STEP_LO 16'd50
`define LRC_MV_BASE_HI 16'd1700
`define LRC_MV_STEP_HI 16'd100
`define LRC_CODE_KNEE 5'h0f
// Interrupt status bit positions.
`define LRC_IRQ_UV 0
`define LRC_IRQ_RESET 1
`endif

// ==== core/lrc_pkg.sv ====
package lrc_pkg;
  typedef enum logic [1:0] {
    LRC_ACT_IGNORE = 2'h0,
    LRC_ACT_REG_OFF = 2'h1,
    LRC_ACT_SYS_RESET = 2'h2,
    LRC_ACT_RESERVED = 2'h3
  } lrc_action_e;

  typedef enum logic [1:0] {
    LRC_OFF = 2'h0,
    LRC_NORMAL = 2'h1,
    LRC_LOWPWR = 2'h3
  } lrc_state_e;

  typedef struct packed {
    logic enable;
    logic low_power;
    logic lp_variant;
    logic discharge;
    logic switch_mode;
    logic [4:0] voltage_code;
    logic [15:0] millivolts;
  } lrc_drive_s;
endpackage

// ==== core/lrc_vmap.sv ====
`timescale 1ns/1ps
`include "lrc_defs.svh"
module lrc_vmap
  import lrc_pkg::*;
(
  input wire logic [4:0] code_i,
  output logic [15:0] mv_o
);
  // Two linear segments meeting at the knee code.
  always_comb begin
    if (code_i < `LRC_CODE_KNEE) begin
      mv_o = `LRC_MV_BASE_LO + 16'(code_i) * `LRC_MV_STEP_LO; // R10
    end else begin
      mv_o = `LRC_MV_BASE_HI + 16'(code_i - `LRC_CODE_KNEE) * `LRC_MV_STEP_HI; // R11
    end
  end
endmodule

// ==== core/lrc_hwsel.sv ====
`timescale 1ns/1ps
`include "lrc_defs.svh"
module lrc_hwsel
  import lrc_pkg::*;
(
  input wire logic [1:0] source_i,
  input wire logic hwc1_i,
  input wire logic hwc2_i,
  output logic active_o
);
  // Source code picks the governing hardware-control input.
  always_comb begin
    unique case (source_i)
      2'h0: active_o = 1'b0; // R03
      2'h1: active_o = hwc1_i; // R03
      2'h2: active_o = hwc2_i; // R03
      2'h3: active_o = hwc1_i | hwc2_i; // R03
    endcase
  end
endmodule

// ==== core/lrc_bank.sv ====
`timescale 1ns/1ps
`include "lrc_defs.svh"
module lrc_bank
  import lrc_pkg::*;
(
  input wire logic CLK_SYS_I,
  input wire logic RESET_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [17:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic HWC1_I,
  input wire logic HWC2_I,
  input wire logic HWEN1_I,
  input wire logic HWEN2_I,
  input wire logic SEQ_ACTIVE_I,
  input wire logic [2:0] SEQ_SLOT_I,
  input wire logic UNDERVOLTAGE_I,
  output lrc_drive_s REG_DRIVE_O,
  output logic SYS_RESET_REQ_O,
  output logic IRQ_O
);
  logic [15:0] ctrl_q;
  logic [15:0] on_q;
  logic [15:0] slp_q;
  logic [1:0] irq_stat_q;
  logic [1:0] irq_mask_q;
  logic uv_off_q;
  logic uv_prev_q;
  logic slot_reached_q;
  logic hw_active;
  logic [15:0] mv;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic uv_rise;
  logic sys_rst_evt;
  logic en_d;
  logic lp_d;
  logic [4:0] code_d;
  logic [2:0] slot;
  lrc_action_e action;
  lrc_state_e state_d;
  lrc_drive_s drive_d;

  assign slot = on_q[`LRC_SLOT_HI:`LRC_SLOT_LO];
  assign action = lrc_action_e'(ctrl_q[`LRC_ERR_HI:`LRC_ERR_LO]);
  assign wr_en = PSEL_I & PENABLE_I & PWRITE_I;
  assign rd_en = PSEL_I & ~PENABLE_I & ~PWRITE_I;
  assign uv_rise = UNDERVOLTAGE_I & ~uv_prev_q;
  assign sys_rst_evt = uv_rise & (action == LRC_ACT_SYS_RESET);

  // Address decode; unmapped addresses answer with an error.
  always_comb begin
    unique case (PADDR_I)
      `LRC_ADDR_CTRL, `LRC_ADDR_ON, `LRC_ADDR_SLP, `LRC_ADDR_IRQ_STAT,
      `LRC_ADDR_IRQ_MASK, `LRC_ADDR_STATUS: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  lrc_hwsel u_hwsel (
    .source_i(ctrl_q[`LRC_SRC_HI:`LRC_SRC_LO]),
    .hwc1_i(HWC1_I),
    .hwc2_i(HWC2_I),
    .active_o(hw_active)
  );

  lrc_vmap u_vmap (
    .code_i(code_d),
    .mv_o(mv)
  );

  // Configuration registers; only the low half-word is stored.
  always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
    if (RESET_I) begin
      ctrl_q <= `LRC_CTRL_RST; // R12
      on_q <= `LRC_ON_RST; // R12
      slp_q <= `LRC_SLP_RST;
      irq_mask_q <= 2'h0;
    end else if (wr_en) begin
      unique case (PADDR_I)
        `LRC_ADDR_CTRL: ctrl_q <= PWDATA_I[15:0];
        `LRC_ADDR_ON: on_q <= PWDATA_I[15:0];
        `LRC_ADDR_SLP: slp_q <= PWDATA_I[15:0]; // R13
        `LRC_ADDR_IRQ_MASK: irq_mask_q <= PWDATA_I[1:0];
        default: ;
      endcase
    end
  end

  // Sticky interrupt status; a new event wins over a write-one clear.
  always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
    if (RESET_I) begin
      irq_stat_q <= 2'h0;
    end else begin
      irq_stat_q[`LRC_IRQ_UV] <= uv_rise | (irq_stat_q[`LRC_IRQ_UV] &
        ~(wr_en & (PADDR_I == `LRC_ADDR_IRQ_STAT) & PWDATA_I[`LRC_IRQ_UV])); // R02
      irq_stat_q[`LRC_IRQ_RESET] <= sys_rst_evt | (irq_stat_q[`LRC_IRQ_RESET] &
        ~(wr_en & (PADDR_I == `LRC_ADDR_IRQ_STAT) & PWDATA_I[`LRC_IRQ_RESET]));
    end
  end

  // Fault tracking; the regulator stays off until software rewrites the action field.
  always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
    if (RESET_I) begin
      uv_prev_q <= 1'b0;
      uv_off_q <= 1'b0;
    end else begin
      uv_prev_q <= UNDERVOLTAGE_I;
      if (uv_rise & (action == LRC_ACT_REG_OFF)) begin
        uv_off_q <= 1'b1; // R01
      end else if (wr_en & (PADDR_I == `LRC_ADDR_CTRL)) begin
        uv_off_q <= 1'b0;
      end
    end
  end

  // Sequencer slot latch: enabled once the sequencer reaches the assigned slot.
  always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
    if (RESET_I) begin
      slot_reached_q <= 1'b0;
    end else if (slot == 3'h0 || slot > 3'h5) begin
      slot_reached_q <= 1'b0; // R15
    end else if (SEQ_ACTIVE_I && SEQ_SLOT_I >= slot) begin
      slot_reached_q <= 1'b1; // R15
    end else if (!SEQ_ACTIVE_I && SEQ_SLOT_I == 3'h0) begin
      slot_reached_q <= 1'b0;
    end
  end

  // Regulator drive: ON settings by default, HWC settings while the source is active.
  always_comb begin
    unique case (slot)
      3'h0: en_d = 1'b0; // R08
      3'h6: en_d = HWEN1_I; // R08
      3'h7: en_d = HWEN2_I; // R08
      default: en_d = slot_reached_q; // R08
    endcase
    lp_d = on_q[`LRC_MODE_BIT]; // R09
    code_d = on_q[`LRC_VSEL_HI:`LRC_VSEL_LO];
    if (hw_active) begin // R14
      code_d = ctrl_q[`LRC_HVSEL_BIT] ? slp_q[`LRC_VSEL_HI:`LRC_VSEL_LO] :
        on_q[`LRC_VSEL_HI:`LRC_VSEL_LO]; // R04
      unique case (ctrl_q[`LRC_HMODE_HI:`LRC_HMODE_LO])
        2'h1: en_d = 1'b0; // R05
        2'h3: lp_d = on_q[`LRC_MODE_BIT]; // R05
        default: lp_d = 1'b1; // R05
      endcase
    end
    if (uv_off_q) begin
      en_d = 1'b0; // R01
    end
    state_d = !en_d ? LRC_OFF : (lp_d ? LRC_LOWPWR : LRC_NORMAL);
    drive_d.enable = (state_d != LRC_OFF);
    drive_d.low_power = (state_d == LRC_LOWPWR);
    drive_d.lp_variant = ctrl_q[`LRC_LP_BIT]; // R07
    drive_d.discharge = ~en_d & ~ctrl_q[`LRC_FLT_BIT]; // R06
    drive_d.switch_mode = ctrl_q[`LRC_SWI_BIT];
    drive_d.voltage_code = code_d;
    drive_d.millivolts = mv; // R10
  end

  // Registered outputs toward the regulator and the reset logic.
  always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
    if (RESET_I) begin
      REG_DRIVE_O <= '0;
      SYS_RESET_REQ_O <= 1'b0;
      IRQ_O <= 1'b0;
    end else begin
      REG_DRIVE_O <= drive_d;
      SYS_RESET_REQ_O <= sys_rst_evt; // R01
      IRQ_O <= |(irq_stat_q & irq_mask_q);
    end
  end

  // APB answer: zero wait states; read data is set up during the setup phase.
  always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
    if (RESET_I) begin
      PRDATA_O <= 32'h0;
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
    end else begin
      PREADY_O <= PSEL_I & ~PENABLE_I;
      PSLVERR_O <= PSEL_I & ~PENABLE_I & ~addr_ok;
      if (rd_en) begin
        unique case (PADDR_I)
          `LRC_ADDR_CTRL: PRDATA_O <= {16'h0, ctrl_q};
          `LRC_ADDR_ON: PRDATA_O <= {16'h0, on_q};
          `LRC_ADDR_SLP: PRDATA_O <= {16'h0, slp_q};
          `LRC_ADDR_IRQ_STAT: PRDATA_O <= {30'h0, irq_stat_q};
          `LRC_ADDR_IRQ_MASK: PRDATA_O <= {30'h0, irq_mask_q};
          `LRC_ADDR_STATUS: PRDATA_O <= {28'h0, slot_reached_q, uv_off_q,
            hw_active, drive_d.enable};
          default: PRDATA_O <= 32'h0;
        endcase
      end
    end
  end

  a_reset_defaults: assert property (@(posedge CLK_SYS_I)
    $fell(RESET_I) |-> ctrl_q == `LRC_CTRL_RST && on_q == `LRC_ON_RST) // R12
    else $error("Control registers wrong after reset.");
  a_uv_irq_always: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    uv_rise |=> irq_stat_q[`LRC_IRQ_UV]) // R02
    else $error("Undervoltage did not set interrupt status.");
  a_uv_reg_off: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    uv_rise && action == LRC_ACT_REG_OFF && !wr_en |=> ##1 !REG_DRIVE_O.enable) // R01
    else $error("Regulator not switched off on undervoltage.");
  a_uv_sys_reset: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    uv_rise && action == LRC_ACT_SYS_RESET |=> SYS_RESET_REQ_O) // R01
    else $error("System reset not requested on undervoltage.");
  a_slot_zero_off: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    slot == 3'h0 |=> !REG_DRIVE_O.enable) // R08
    else $error("Regulator on with slot zero.");
  a_hwc_mode_off: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    hw_active && ctrl_q[`LRC_HMODE_HI:`LRC_HMODE_LO] == 2'h1 |=> !REG_DRIVE_O.enable) // R05
    else $error("HWC off mode left regulator on.");
  a_hwc_vsel: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    hw_active && ctrl_q[`LRC_HVSEL_BIT] |=>
    REG_DRIVE_O.voltage_code == $past(slp_q[`LRC_VSEL_HI:`LRC_VSEL_LO])) // R04
    else $error("HWC voltage not from sleep code.");
  a_discharge_off: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    REG_DRIVE_O.discharge |-> !REG_DRIVE_O.enable) // R06
    else $error("Discharge while enabled.");
  a_on_mode_lp: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    !hw_active && en_d |=> REG_DRIVE_O.low_power == $past(on_q[`LRC_MODE_BIT])) // R09
    else $error("ON mode not followed.");
  a_max_code: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    code_d == 5'h1f |-> mv == 16'd3300) // R11
    else $error("Top code not 3.3V.");
  c_uv_event: cover property (@(posedge CLK_SYS_I) disable iff (RESET_I) uv_rise);
  c_hw_ctrl: cover property (@(posedge CLK_SYS_I) disable iff (RESET_I) hw_active && en_d);
  c_slot_on: cover property (@(posedge CLK_SYS_I) disable iff (RESET_I) $rose(slot_reached_q));
endmodule

// ==== bench/lrc_seq_model.sv ====
`timescale 1ns/1ps
// Power-up sequencer stand-in: walks timeslots 1 to 5, eight cycles each, then idles at slot 0.
module lrc_seq_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  output logic active_o,
  output logic [2:0] slot_o
);
  logic [2:0] cnt_q;
  // Slot stepping; a start request while running is ignored, as a real sequencer would.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      active_o <= 1'b0;
      slot_o <= 3'h0;
      cnt_q <= 3'h0;
    end else if (start_i && !active_o) begin
      active_o <= 1'b1;
      slot_o <= 3'h1;
      cnt_q <= 3'h0;
    end else if (active_o) begin
      cnt_q <= cnt_q + 3'h1;
      if (cnt_q == 3'h7) begin
        active_o <= (slot_o != 3'h5);
        slot_o <= (slot_o == 3'h5) ? 3'h0 : slot_o + 3'h1;
      end
    end
  end
endmodule

// ==== bench/lrc_bank_tb_top.sv ====
`timescale 1ns/1ps
`include "lrc_defs.svh"
module lrc_bank_tb_top
  import lrc_pkg::*;
;
  logic clk, rst, psel, pen, pwr, hwc1, hwc2, hwen1, hwen2, uv, start, rerr;
  logic pready, pslverr, sysrst, irq, sact;
  logic [2:0] sslot;
  logic [17:0] addr;
  logic [31:0] wdat, rdat, prdata;
  lrc_drive_s drv;
  int failures, n_tests, cyc, npulse;
  logic [4:0] codes[5] = '{5'h00, 5'h01, 5'h0e, 5'h0f, 5'h1f};
  logic [2:0] slots[3] = '{3'h0, 3'h5, 3'h3};
  logic [15:0] hc[6] = '{16'h0f01, 16'h0d01, 16'h0d81, 16'h0c01, 16'h0a00, 16'h0f01};
  logic [8:0] he[6] = '{9'h151, 9'h020, 9'h000, 9'h1d1, 9'h184, 9'h144};
  logic [8:0] hm[6] = '{9'h1ff, 9'h120, 9'h120, 9'h1ff, 9'h1ff, 9'h1ff};

  lrc_bank lrc_bank_inst (.CLK_SYS_I(clk), .RESET_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(addr), .PWDATA_I(wdat), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .HWC1_I(hwc1), .HWC2_I(hwc2), .HWEN1_I(hwen1), .HWEN2_I(hwen2),
    .SEQ_ACTIVE_I(sact), .SEQ_SLOT_I(sslot), .UNDERVOLTAGE_I(uv), .REG_DRIVE_O(drv),
    .SYS_RESET_REQ_O(sysrst), .IRQ_O(irq));
  lrc_seq_model lrc_seq_model_inst (.clk_i(clk), .rst_i(rst), .start_i(start),
    .active_o(sact), .slot_o(sslot));

  // Free-running system clock.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Hang guard; counts as a mismatch so a stall can never pass.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      wrap_up();
    end
    if (sysrst === 1'b1) npulse++;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  // One APB transfer; the request is held until pready is seen high at an edge.
  task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1; pen <= 1'b0; pwr <= w; addr <= a; wdat <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) failures++;
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0; pen <= 1'b0;
  endtask

  task automatic rd(input logic [17:0] a, input logic [31:0] e, input string m);
    apb(1'b0, a, 32'h0);
    chk(rdat, e, m);
  endtask

  task automatic wslot(input logic [2:0] s);
    int n;
    n = 0;
    while (sslot !== s && n < 200) begin
      @(posedge clk);
      n++;
    end
    repeat (3) @(posedge clk);
  endtask

  function automatic logic [15:0] mv(input logic [4:0] c);
    return (c < 5'h0f) ? 16'd900 + 16'd50 * c : 16'd1700 + 16'd100 * (c - 5'h0f);
  endfunction

  // Main sequence.
  initial begin
    {psel, pen, pwr, hwc1, hwc2, hwen1, hwen2, uv, start} = '0;
    addr = '0; wdat = '0; rst = 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd(`LRC_ADDR_CTRL, 32'h0200, "ctrl reset");
    rd(`LRC_ADDR_ON, 32'h0, "on reset");
    apb(1'b0, 18'h101fc, 32'h0);
    chk({31'h0, rerr}, 32'h1, "unmapped");
    $display("test reset done");
    foreach (codes[i]) begin
      apb(1'b1, `LRC_ADDR_ON, {27'h0, codes[i]});
      repeat (3) @(posedge clk);
      chk({16'h0, drv.millivolts}, {16'h0, mv(codes[i])}, "millivolts");
    end
    $display("test voltage done");
    // Sequencer slots, then the two hardware enable codes.
    foreach (slots[i]) begin
      apb(1'b1, `LRC_ADDR_ON, {16'h0, slots[i], 13'h0004});
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      if (slots[i] > 3'h1) begin
        wslot(slots[i] - 3'h1);
        chk({31'h0, drv.enable}, 32'h0, "early enable");
      end
      wslot((slots[i] == 3'h0) ? 3'h5 : slots[i]);
      chk({31'h0, drv.enable}, {31'h0, slots[i] != 3'h0}, "slot enable");
      wslot(3'h0);
    end
    for (int j = 0; j < 4; j++) begin
      apb(1'b1, `LRC_ADDR_ON, {16'h0, j[1] ? 3'h7 : 3'h6, 13'h0004});
      hwen1 <= j[0] & ~j[1];
      hwen2 <= j[0] & j[1];
      repeat (3) @(posedge clk);
      chk({31'h0, drv.enable}, {31'h0, j[0]}, "hw enable");
    end
    apb(1'b1, `LRC_ADDR_ON, 32'hc004);
    hwen1 <= 1'b1;
    hwen2 <= 1'b0;
    $display("test slots done");
    // Only input 2 active: the source code decides whether the sleep code applies.
    apb(1'b1, `LRC_ADDR_SLP, 32'h0011);
    hwc2 <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, `LRC_ADDR_CTRL, {16'h0, 3'h0, s[1:0], 11'h701});
      repeat (3) @(posedge clk);
      chk({27'h0, drv.voltage_code}, s[1] ? 32'h11 : 32'h04, "source");
    end
    hwc2 <= 1'b0;
    foreach (hc[i]) begin
      apb(1'b1, `LRC_ADDR_CTRL, {16'h0, hc[i]});
      hwc1 <= (i != 5);
      repeat (3) @(posedge clk);
      chk({23'h0, {drv.enable, drv.low_power, drv.lp_variant, drv.discharge,
        drv.voltage_code} & hm[i]}, {23'h0, he[i]}, "hw mode");
    end
    apb(1'b1, `LRC_ADDR_ON, 32'hc104);
    repeat (3) @(posedge clk);
    chk({31'h0, drv.low_power}, 32'h1, "on mode");
    rd(`LRC_ADDR_STATUS, 32'h1, "status");
    $display("test hw control done");
    // Undervoltage under each defined action, then masked.
    apb(1'b1, `LRC_ADDR_IRQ_MASK, 32'h3);
    for (int a = 0; a < 3; a++) begin
      apb(1'b1, `LRC_ADDR_CTRL, {16'h0, a[1:0], 14'h0});
      apb(1'b1, `LRC_ADDR_IRQ_STAT, 32'h3);
      npulse = 0;
      uv <= 1'b1;
      repeat (4) @(posedge clk);
      uv <= 1'b0;
      chk({31'h0, irq}, 32'h1, "irq raised");
      chk({31'h0, drv.enable}, {31'h0, a != 1}, "uv off");
      chk(npulse, {31'h0, a == 2}, "sys reset");
      rd(`LRC_ADDR_IRQ_STAT, (a == 2) ? 32'h3 : 32'h1, "irq status");
      apb(1'b1, `LRC_ADDR_IRQ_STAT, 32'h3);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h0, "irq cleared");
    end
    apb(1'b1, `LRC_ADDR_IRQ_MASK, 32'h0);
    uv <= 1'b1;
    repeat (4) @(posedge clk);
    chk({31'h0, irq}, 32'h0, "irq masked");
    $display("test undervoltage done");
    wrap_up();
  end
endmodule
